// ==== logic/upsb_pkg.sv ====
package upsb_pkg;
  // Frame delimiters and status codes
  localparam logic [7:0] UPSB_SOH      = 8'h01;
  localparam logic [7:0] UPSB_STX      = 8'h02;
  localparam logic [7:0] UPSB_ETX      = 8'h03;
  localparam logic [7:0] UPSB_STAT_LEN = 8'h01;
  localparam logic [7:0] UPSB_ACK      = 8'h06;
  localparam logic [7:0] UPSB_SUM_ERR  = 8'h07;
  localparam logic [7:0] UPSB_NACK     = 8'h15;
  localparam logic [7:0] UPSB_SYNC_BYTE = 8'h00;
  // Command frame layout
  localparam logic [7:0] UPSB_MAX_LEN   = 8'h05;
  localparam logic [7:0] UPSB_RESET_LEN = 8'h01;
  localparam logic [7:0] UPSB_BAUD_LEN  = 8'h05;
  localparam logic [7:0] UPSB_PARAM_THREE_FIXED = 8'h0a;
  localparam int         UPSB_BUF_WORDS = 5;
  // Sequencing counts
  localparam logic [1:0] UPSB_SYNC_PULSES = 2'h2;
  localparam logic [3:0] UPSB_MISS_LAST   = 4'hf;
  localparam logic [2:0] UPSB_STAT_LAST   = 3'h4;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } upsb_byte_type;
endpackage

// ==== logic/upsb_pair_buf.sv ====
module upsb_pair_buf #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic             i_ref_clk,
  input  wire logic             i_resetn,
  // Fill side
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  // Drain side
  output logic                  o_out_valid,
  output logic [WIDTH-1:0]      o_out_data,
  input  wire logic             i_out_ready
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0]    wr_reg;
  logic [PW-1:0]    wr_next;
  logic [PW-1:0]    rd_reg;
  logic [PW-1:0]    rd_next;
  logic [PW:0]      cnt_reg;
  logic [PW:0]      cnt_next;
  logic             push;
  logic             pop;

  assign o_in_ready  = (cnt_reg != (PW+1)'(DEPTH));
  assign o_out_valid = (cnt_reg != '0);
  assign o_out_data  = mem_reg[rd_reg];
  assign push = i_in_valid && o_in_ready;
  assign pop  = o_out_valid && i_out_ready;

  always_comb
  begin
    wr_next  = wr_reg;
    rd_next  = rd_reg;
    cnt_next = cnt_reg;
    if (push)
    begin
      wr_next = (wr_reg == PW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
    end
    if (pop)
    begin
      rd_next = (rd_reg == PW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
    end
    if (push && !pop)
    begin
      cnt_next = cnt_reg + 1'b1;
    end
    else if (pop && !push)
    begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      cnt_reg <= cnt_next;
    end
  end

  // Storage needs no reset; empty flag hides stale words
  always_ff @(posedge i_ref_clk)
  begin
    if (push)
    begin
      mem_reg[wr_reg] <= i_in_data;
    end
  end
endmodule

// ==== logic/upsb_cmd_core.sv ====
module upsb_cmd_core #(
  parameter logic [7:0] CMD_RESET    = 8'h00,
  parameter logic [7:0] CMD_BAUD     = 8'h9a,
  parameter logic [7:0] MAX_BAUD_SEL = 8'h07
) (
  // Clock and reset
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_resetn,
  // Received bytes from the UART receiver
  input  wire upsb_pkg::upsb_byte_type i_rx,
  output logic                       o_rx_ready,
  // Status bytes toward the UART transmitter
  output upsb_pkg::upsb_byte_type    o_tx,
  input  wire logic                  i_tx_ready,
  // Link state
  output logic                       o_synced,
  output logic [7:0]                 o_baud_sel,
  output logic                       o_noise_filter,
  output logic                       o_mute,
  output logic                       o_cmd_valid,
  output logic [7:0]                 o_cmd_code
);
  typedef enum logic [2:0] {
    S_SYNC, S_HUNT, S_LEN, S_BODY, S_SUM, S_ETX, S_SEND
  } upsb_state_type;

  upsb_state_type state_reg, state_next;
  logic [7:0] buf_reg [upsb_pkg::UPSB_BUF_WORDS];
  logic [7:0] buf_next [upsb_pkg::UPSB_BUF_WORDS];
  logic [7:0] len_reg, len_next, sum_reg, sum_next;
  logic [7:0] status_reg, status_next, baud_reg, baud_next;
  logic [7:0] code_reg, code_next;
  logic [2:0] idx_reg, idx_next;
  logic [1:0] zero_reg, zero_next;
  logic [3:0] miss_reg, miss_next;
  logic       cks_reg, cks_next, sync_reg, sync_next, post_reg, post_next;
  logic       mute_reg, mute_next, filt_reg, filt_next;
  logic       cmdv_reg, cmdv_next;
  logic       take, fin, f_bad, f_good, f_baud, f_baud_ok, f_reset;
  logic [7:0] rx_byte, push_data;
  logic       push_valid, push_ready, push;

  assign rx_byte    = i_rx.data;
  assign o_rx_ready = (state_reg != S_SEND) && !mute_reg;
  assign take       = i_rx.valid && o_rx_ready;
  // A frame ends at its end byte, or early on a length it cannot hold
  assign fin = take && ((state_reg == S_ETX) || ((state_reg == S_LEN) &&
               (rx_byte == 8'h00 || rx_byte > upsb_pkg::UPSB_MAX_LEN)));
  assign f_bad  = (state_reg == S_LEN) || (rx_byte != upsb_pkg::UPSB_ETX);
  assign f_good = fin && !f_bad && cks_reg;
  assign f_baud = (state_reg == S_ETX) && (buf_reg[0] == CMD_BAUD);
  assign f_reset = f_good && (buf_reg[0] == CMD_RESET)
                   && (len_reg == upsb_pkg::UPSB_RESET_LEN);
  assign f_baud_ok = f_good && f_baud
                     && (len_reg == upsb_pkg::UPSB_BAUD_LEN)
                     && (buf_reg[1] <= MAX_BAUD_SEL)
                     && (buf_reg[3] == upsb_pkg::UPSB_PARAM_THREE_FIXED);

  always_comb
  begin
    state_next  = state_reg;
    buf_next    = buf_reg;
    len_next    = len_reg;
    sum_next    = sum_reg;
    status_next = status_reg;
    baud_next   = baud_reg;
    code_next   = code_reg;
    idx_next    = idx_reg;
    zero_next   = zero_reg;
    miss_next   = miss_reg;
    cks_next    = cks_reg;
    sync_next   = sync_reg;
    post_next   = post_reg;
    mute_next   = mute_reg;
    filt_next   = filt_reg;
    cmdv_next   = 1'b0;
    unique case (state_reg)
      S_SYNC:
        if (take && rx_byte == upsb_pkg::UPSB_SYNC_BYTE)
        begin
          zero_next = zero_reg + 2'h1;
          if (zero_next == upsb_pkg::UPSB_SYNC_PULSES)
          begin
            state_next = S_HUNT;
          end
        end
      S_HUNT:
        if (take && rx_byte == upsb_pkg::UPSB_SOH)
        begin
          state_next = S_LEN;
        end
      S_LEN:
        if (take)
        begin
          len_next   = rx_byte;
          sum_next   = rx_byte;
          idx_next   = 3'h0;
          state_next = S_BODY;
        end
      S_BODY:
        if (take)
        begin
          buf_next[idx_reg] = rx_byte;
          sum_next = sum_reg + rx_byte;
          idx_next = idx_reg + 3'h1;
          if (8'(idx_reg) + 8'h01 == len_reg)
          begin
            state_next = S_SUM;
          end
        end
      S_SUM:
        if (take)
        begin
          cks_next   = (8'(sum_reg + rx_byte) == 8'h00);
          state_next = S_ETX;
        end
      S_ETX: ;
      S_SEND:
        if (push && idx_reg == upsb_pkg::UPSB_STAT_LAST)
        begin
          state_next = S_HUNT;
        end
        else if (push)
        begin
          idx_next = idx_reg + 3'h1;
        end
    endcase
    if (fin)
    begin
      state_next = S_HUNT;
      idx_next   = 3'h0;
      if (post_reg)
      begin
        if (f_reset)
        begin
          post_next   = 1'b0;
          sync_next   = 1'b1;
          status_next = upsb_pkg::UPSB_ACK;
          state_next  = S_SEND;
        end
        else
        begin
          // Silent count of frames seen at the new rate
          miss_next = miss_reg + 4'h1;
          if (miss_reg == upsb_pkg::UPSB_MISS_LAST)
          begin
            mute_next = 1'b1;
          end
        end
      end
      else if (f_baud)
      begin
        // Faulty frames fall through silently, rate unchanged
        if (f_baud_ok)
        begin
          baud_next = buf_reg[1];
          filt_next = buf_reg[4][0];
          post_next = 1'b1;
          sync_next = 1'b0;
          miss_next = 4'h0;
        end
      end
      else if (f_bad)
      begin
        status_next = upsb_pkg::UPSB_NACK;
        state_next  = S_SEND;
      end
      else if (!cks_reg)
      begin
        status_next = upsb_pkg::UPSB_SUM_ERR;
        state_next  = S_SEND;
      end
      else if (f_reset)
      begin
        sync_next   = 1'b1;
        status_next = upsb_pkg::UPSB_ACK;
        state_next  = S_SEND;
      end
      else
      begin
        // Other commands are handed on; their owner answers
        cmdv_next = 1'b1;
        code_next = buf_reg[0];
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state_reg  <= S_SYNC;
      for (int i = 0; i < upsb_pkg::UPSB_BUF_WORDS; i++)
      begin
        buf_reg[i] <= 8'h00;
      end
      len_reg    <= 8'h00;
      sum_reg    <= 8'h00;
      status_reg <= 8'h00;
      baud_reg   <= 8'h00;
      code_reg   <= 8'h00;
      idx_reg    <= 3'h0;
      zero_reg   <= 2'h0;
      miss_reg   <= 4'h0;
      cks_reg    <= 1'b0;
      sync_reg   <= 1'b0;
      post_reg   <= 1'b0;
      mute_reg   <= 1'b0;
      filt_reg   <= 1'b0;
      cmdv_reg   <= 1'b0;
    end
    else
    begin
      state_reg  <= state_next;
      buf_reg    <= buf_next;
      len_reg    <= len_next;
      sum_reg    <= sum_next;
      status_reg <= status_next;
      baud_reg   <= baud_next;
      code_reg   <= code_next;
      idx_reg    <= idx_next;
      zero_reg   <= zero_next;
      miss_reg   <= miss_next;
      cks_reg    <= cks_next;
      sync_reg   <= sync_next;
      post_reg   <= post_next;
      mute_reg   <= mute_next;
      filt_reg   <= filt_next;
      cmdv_reg   <= cmdv_next;
    end
  end

  // Status frame bytes in order
  always_comb
  begin
    unique case (idx_reg)
      3'h0:    push_data = upsb_pkg::UPSB_STX;
      3'h1:    push_data = upsb_pkg::UPSB_STAT_LEN;
      3'h2:    push_data = status_reg;
      3'h3:    push_data = 8'(8'h00 - upsb_pkg::UPSB_STAT_LEN - status_reg);
      default: push_data = upsb_pkg::UPSB_ETX;
    endcase
  end
  assign push_valid = (state_reg == S_SEND);
  assign push       = push_valid && push_ready;

  // Transmitter stall holds bytes here; parser stops taking input only until the last byte is pushed
  upsb_pair_buf #(.WIDTH(8), .DEPTH(2)) u_tx_buf (
    .i_ref_clk   (i_ref_clk),
    .i_resetn    (i_resetn),
    .i_in_valid  (push_valid),
    .i_in_data   (push_data),
    .o_in_ready  (push_ready),
    .o_out_valid (o_tx.valid),
    .o_out_data  (o_tx.data),
    .i_out_ready (i_tx_ready)
  );

  assign o_synced       = sync_reg;
  assign o_baud_sel     = baud_reg;
  assign o_noise_filter = filt_reg;
  assign o_mute         = mute_reg;
  assign o_cmd_valid    = cmdv_reg;
  assign o_cmd_code     = code_reg;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);

  sequence s_status_out(logic [7:0] code);
    (state_reg == S_SEND) && (status_reg == code) && !o_rx_ready;
  endsequence
  property p_ack_reset;
    fin && !post_reg && !f_baud && f_reset |=> s_status_out(8'h06);
  endproperty
  a_ack_reset: assert property (p_ack_reset)
    else $error("no ack");
  property p_sum_err;
    fin && !post_reg && !f_baud && !f_bad && !cks_reg
      |=> s_status_out(8'h07);
  endproperty
  a_sum_err: assert property (p_sum_err)
    else $error("no 07");
  property p_nack;
    fin && !post_reg && (state_reg == S_LEN) |=> s_status_out(8'h15);
  endproperty
  a_nack: assert property (p_nack)
    else $error("no nack");
  property p_baud_switch;
    fin && !post_reg && f_baud_ok
      |=> post_reg && (o_baud_sel == $past(buf_reg[1]));
  endproperty
  a_baud_switch: assert property (p_baud_switch)
    else $error("no switch");
  property p_baud_silent;
    fin && !post_reg && f_baud |=> (state_reg == S_HUNT) ##1 !push_valid;
  endproperty
  a_baud_silent: assert property (p_baud_silent)
    else $error("baud reply");
  property p_bad_baud_keep;
    fin && !post_reg && f_baud && !f_baud_ok
      |=> $stable(o_baud_sel) && !post_reg && (state_reg == S_HUNT);
  endproperty
  a_bad_baud_keep: assert property (p_bad_baud_keep)
    else $error("bad baud");
  property p_mute;
    fin && post_reg && !f_reset && (miss_reg == 4'hf)
      |=> o_mute ##1 (o_mute && !o_rx_ready)[*3];
  endproperty
  a_mute: assert property (p_mute)
    else $error("not muted");
  property p_frame_bytes;
    push |-> (idx_reg != 3'h3 || 8'(push_data + status_reg + 8'h01) == 8'h00)
      && (idx_reg != 3'h0 || push_data == 8'h02)
      && (idx_reg != 3'h4 || push_data == 8'h03);
  endproperty
  a_frame_bytes: assert property (p_frame_bytes)
    else $error("bad frame");
endmodule

// ==== testbench/upsb_prog_model.sv ====
module upsb_prog_model (
  // Clock
  input  wire logic                    i_ref_clk,
  // Byte stream toward the device
  input  wire logic                    i_rx_ready,
  output upsb_pkg::upsb_byte_type      o_rx,
  // Status stream from the device
  output logic                         o_tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;

  localparam int GAP = 4;

  initial
  begin
    o_rx       = '0;
    o_tx_ready = 1'b0;
  end

  // Random stalls so the status buffer really fills
  always @(posedge i_ref_clk)
    o_tx_ready <= ($urandom_range(3) != 0);

  // Held until the edge that sees ready high
  task automatic send_byte(input logic [7:0] b);
    #1;
    o_rx.valid = 1'b1;
    o_rx.data  = b;
    do @(posedge i_ref_clk); while (i_rx_ready !== 1'b1);
  endtask

  // Released line shows the inverse, not a stale byte
  task automatic release_line();
    #1;
    o_rx.valid = 1'b0;
    o_rx.data  = ~o_rx.data;
  endtask

  task automatic pause();
    release_line();
    repeat (GAP) @(posedge i_ref_clk);
  endtask

  // Two zero bytes with a gap between
  task automatic sync_pulses();
    send_byte(upsb_pkg::UPSB_SYNC_BYTE);
    pause();
    send_byte(upsb_pkg::UPSB_SYNC_BYTE);
    pause();
  endtask

  task automatic frame(input logic [7:0]  com,
                       input logic [31:0] dat,
                       input int          nd,
                       input logic [7:0]  sum_err,
                       input logic [7:0]  etx);
    logic [7:0] len;
    logic [7:0] sum;
    len = 8'(nd + 1);
    sum = 8'h00 - len - com + sum_err;
    for (int i = 0; i < nd; i++)
      sum = sum - dat[31-8*i -: 8];
    send_byte(upsb_pkg::UPSB_SOH);
    send_byte(len);
    send_byte(com);
    for (int i = 0; i < nd; i++)
      send_byte(dat[31-8*i -: 8]);
    send_byte(sum);
    send_byte(etx);
    pause();
  endtask
endmodule

// ==== testbench/upsb_cmd_core_test.sv ====
module upsb_cmd_core_test;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [7:0] RST  = 8'h00;
  localparam logic [7:0] BAUD = 8'h9a;
  localparam logic [7:0] ETX  = upsb_pkg::UPSB_ETX;

  logic                    clk;
  logic                    resetn;
  upsb_pkg::upsb_byte_type rx;
  logic                    rx_ready;
  upsb_pkg::upsb_byte_type tx;
  logic                    tx_ready;
  logic                    synced;
  logic [7:0]              baud_sel;
  logic                    filt;
  logic                    mute;
  logic                    cmd_valid;
  logic [7:0]              cmd_code;
  logic [7:0]              exp_q[$];
  logic [7:0]              sel;
  int                      n_mismatch;
  int                      check_count;
  int                      n_cmd;
  int                      cyc;

  upsb_cmd_core #(.CMD_RESET(RST), .CMD_BAUD(BAUD),
    .MAX_BAUD_SEL(8'h07)) dut_u (
    .i_ref_clk(clk), .i_resetn(resetn), .i_rx(rx),
    .o_rx_ready(rx_ready), .o_tx(tx), .i_tx_ready(tx_ready),
    .o_synced(synced), .o_baud_sel(baud_sel), .o_noise_filter(filt),
    .o_mute(mute), .o_cmd_valid(cmd_valid), .o_cmd_code(cmd_code));

  upsb_prog_model prog_u (
    .i_ref_clk(clk), .i_rx_ready(rx_ready), .o_rx(rx),
    .o_tx_ready(tx_ready));

  initial clk = 1'b0;
  always #10 clk = ~clk;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      n_mismatch++;
    end
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Unexpected status bytes meet an unknown and fail
  always @(posedge clk)
  begin
    if (resetn && tx.valid === 1'b1 && tx_ready === 1'b1)
      chk(tx.data, exp_q.size() ? exp_q.pop_front() : 8'hxx);
    if (cmd_valid === 1'b1)
      n_cmd++;
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  task automatic status(input logic [7:0] st);
    exp_q.push_back(upsb_pkg::UPSB_STX);
    exp_q.push_back(upsb_pkg::UPSB_STAT_LEN);
    exp_q.push_back(st);
    exp_q.push_back(8'h00 - upsb_pkg::UPSB_STAT_LEN - st);
    exp_q.push_back(ETX);
  endtask

  // Bounded wait for the status, then quiet time
  task automatic settle();
    int i;
    i = 0;
    while (exp_q.size() != 0 && i < 400)
    begin
      @(posedge clk);
      i++;
    end
    chk(8'(exp_q.size()), 8'h00);
    repeat (30) @(posedge clk);
  endtask

  // Bad status means another Reset, never past 16 sends
  task automatic reset_retry(input int n_bad);
    int tries;
    tries = 0;
    do
    begin
      status(tries < n_bad ? upsb_pkg::UPSB_SUM_ERR : upsb_pkg::UPSB_ACK);
      prog_u.frame(RST, 0, 0, 8'(tries < n_bad), ETX);
      settle();
      tries++;
    end
    while (synced !== 1'b1 && tries < 16);
    chk(8'(tries), 8'(n_bad + 1));
  endtask

  task automatic baud(input logic [7:0] s, input logic [7:0] d3);
    prog_u.frame(BAUD, {s, 8'h00, d3, 8'h01}, 4, 8'h00, ETX);
    settle();
  endtask

  initial
  begin
    void'($urandom(41149));
    resetn = 1'b0;
    n_mismatch = 0;
    check_count = 0;
    n_cmd = 0;
    cyc = 0;
    repeat (5) @(posedge clk);
    #1 resetn = 1'b1;
    prog_u.send_byte(8'h55);
    prog_u.sync_pulses();
    reset_retry(1 + $urandom_range(2));
    chk(8'(synced), 8'h01);
    status(upsb_pkg::UPSB_SUM_ERR);
    prog_u.frame(RST, 0, 0, 8'h01, ETX);
    settle();
    status(upsb_pkg::UPSB_NACK);
    prog_u.frame(RST, 0, 0, 8'h01, 8'h04);
    settle();
    status(upsb_pkg::UPSB_NACK);
    prog_u.send_byte(upsb_pkg::UPSB_SOH);
    prog_u.send_byte(8'h00);
    prog_u.pause();
    settle();
    prog_u.frame(8'h55, 0, 0, 8'h00, ETX);
    settle();
    chk(8'(n_cmd), 8'h01);
    chk(cmd_code, 8'h55);
    // Faulty rate frames stay silent and change nothing
    baud(8'(8 + $urandom_range(247)), 8'h0a);
    baud(8'h01, 8'h0b);
    prog_u.frame(BAUD, 32'h010a0a01, 4, 8'h01, ETX);
    settle();
    chk(baud_sel, 8'h00);
    chk(8'(synced), 8'h01);
    sel = 8'($urandom_range(7));
    baud(sel, 8'h0a);
    chk(baud_sel, sel);
    chk(8'(filt), 8'h01);
    chk(8'(synced), 8'h00);
    status(upsb_pkg::UPSB_ACK);
    prog_u.frame(RST, 0, 0, 8'h00, ETX);
    settle();
    chk(8'(synced), 8'h01);
    baud(8'h07, 8'h0a);
    repeat (15) prog_u.frame(8'h55, 0, 0, 8'h00, ETX);
    settle();
    chk(8'(mute), 8'h00);
    prog_u.frame(8'h55, 0, 0, 8'h00, ETX);
    settle();
    chk(8'(mute), 8'h01);
    chk(8'(rx_ready), 8'h00);
    chk(8'(n_cmd), 8'h01);
    // Hardware reset is the only way out of the muted state
    #1 resetn = 1'b0;
    repeat (5) @(posedge clk);
    #1 resetn = 1'b1;
    @(posedge clk);
    chk(8'(mute), 8'h00);
    chk(8'(rx_ready), 8'h01);
    tally_and_finish();
  end
endmodule
